/* File: hdl/gss_map.vh */
// constants for the graticule scan sequencer
`ifndef GSS_MAP_VH
`define GSS_MAP_VH

// register offsets (index on the plain register port)
`define GSS_OFS_CTRL        4'h0
`define GSS_OFS_STATUS      4'h1
`define GSS_OFS_COLUMN      4'h2

// control register fields
`define GSS_CTRL_VIDEO      0
`define GSS_CTRL_OVERLAY    1
`define GSS_CTRL_RESET      8'h01

// status register fields
`define GSS_ST_BUSY         0
`define GSS_ST_INHIBIT      1
`define GSS_ST_CHAN_GRAT    2
`define GSS_ST_STAIR_CLEAR  3
`define GSS_ST_SLOW_SWEEP   4
`define GSS_ST_RAMP_RUN     5

// clock rate and timing figures
`define GSS_CLK_MHZ         250
`define GSS_SLOW_SWEEP_NS   50000
`define GSS_SLOW_SWEEP_CYC  ((`GSS_SLOW_SWEEP_NS * `GSS_CLK_MHZ) / 1000)

// divider moduli and counts
`define GSS_DIV_FIRST       8
`define GSS_DIV_MINOR       5
`define GSS_DIV_REF         45
`define GSS_MAJOR_DOTS      41
`define GSS_MINOR_DOTS      9
`define GSS_COL_STEPS       50
`define GSS_MINOR_PER_MAJOR 5

`endif

/* File: hdl/gss_sequencer.v */
// graticule scan sequencer: dividers, retrace flag, phase compare, columns
//
// Summary of operation
// - slow sweeps: one graticule after every sweep
// - slow sweep end: inhibit sweeps, select graticule ramps
// - fast sweeps: no inhibit, still select graticule
// - scan starts lower left, columns sweep upward
// - video major column: 41 dots per sweep
// - minor column: 9 dots, one per major
// - digitize mode: dots only at major intersections
// - each sweep end steps one minor column right
// - after last column: plug-in select, release inhibit
// - divide 5 MHz input by eight
// - divide 625 kHz to reference, one pulse each
// - upper limit clears retrace flag, lower sets
// - correction pulse width equals the time difference
// - retrace first: slow-down high until reference
// - reference first: speed-up low until retrace
// - coincident: slow-down low, speed-up high
// - staircase advances only during retrace
// - count steps, assert staircase clear at count
// - start on gate rise or overlay-only
// - video pattern: one major, four minor, repeat
// - dots at 625 kHz video major, 125 kHz otherwise
// - staircase clear holds until next cycle
//
// Chosen here: the plain strobed port and the address map.

`include "gss_map.vh"

module gss_sequencer #(
	parameter SLOW_CYC   = `GSS_SLOW_SWEEP_CYC, // cycles of a 5 us/div sweep
	parameter DIV_FIRST  = `GSS_DIV_FIRST,      // 5 MHz to 625 kHz
	parameter DIV_MINOR  = `GSS_DIV_MINOR,      // 625 kHz to 125 kHz
	parameter DIV_REF    = `GSS_DIV_REF,        // 625 kHz to reference
	parameter MAJOR_DOTS = `GSS_MAJOR_DOTS,     // dots on a video major line
	parameter MINOR_DOTS = `GSS_MINOR_DOTS,     // dots on a minor line
	parameter COL_STEPS  = `GSS_COL_STEPS       // staircase steps per frame
) (
	input  wire       CLK_I,              // 250 MHz system clock
	input  wire       SYS_RST_I,          // synchronous reset, active high
	input  wire       CE_I,               // clock enable, low freezes all
	input  wire       REF_5M_I,           // 5 MHz reference level
	input  wire       SWEEP_ACTIVE_GATE_I,// high while a sweep runs
	input  wire       UPPER_LIMIT_I,      // ramp reached upper limit
	input  wire       LOWER_LIMIT_I,      // ramp reached lower limit
	input  wire [3:0] ADDR_I,             // register index
	input  wire [7:0] WDATA_I,            // register write data
	input  wire       WR_I,               // write strobe
	input  wire       RD_I,               // read strobe
	output reg  [7:0] RDATA_O,            // read data, cycle after strobe
	output reg        SWEEP_INHIBIT_O,    // locks out the time base
	output reg        CHAN_GRAT_O,        // selectors on graticule ramps
	output reg        STAIR_ADVANCE_O,    // staircase may rise
	output reg        COLUMN_STAIR_CLEAR_O, // staircase held at zero
	output reg        DOT_O,              // one-cycle dot pulse
	output reg        REF_PULSE_O,        // vertical reference pulse
	output reg        RAMP_RUN_O,         // retrace flag, high = ramp
	output reg        SLOW_DOWN_O,        // slope too steep, active high
	output reg        SPEED_UP_N_O        // slope too shallow, active low
);

	// one-hot sequencer states
	localparam [3:0] ST_IDLE  = 4'h1; // waiting for a cycle start
	localparam [3:0] ST_SWEEP = 4'h2; // sweep running, timing its length
	localparam [3:0] ST_SYNC  = 4'h4; // waiting for a ramp start
	localparam [3:0] ST_WRITE = 4'h8; // writing columns

	reg  [3:0]  state;       // sequencer state
	reg         ref_q;       // previous 5 MHz level
	reg  [2:0]  div_first;   // divide-by-eight counter
	reg  [2:0]  div_minor;   // divide-by-five counter
	reg  [5:0]  div_ref;     // divide-by-45 counter
	reg         tick625;     // 625 kHz pulse
	reg         tick125;     // 125 kHz pulse
	reg         gate_q;      // previous sweep gate level
	reg  [15:0] sweep_tmr;   // sweep length timer, saturating
	reg         slow_sweep;  // last sweep was 5 us/div or slower
	reg  [5:0]  step_cnt;    // staircase steps taken
	reg  [2:0]  col_minor;   // column position inside a major division
	reg  [5:0]  dot_cnt;     // dots written in this column
	reg  [7:0]  ctrl;        // control register

	wire video    = ctrl[`GSS_CTRL_VIDEO];   // video vs digitize select
	wire overlay  = ctrl[`GSS_CTRL_OVERLAY]; // overlay only select
	wire tick5    = REF_5M_I & ~ref_q;       // rising edge of 5 MHz
	wire g_rise   = SWEEP_ACTIVE_GATE_I & ~gate_q;
	wire g_fall   = ~SWEEP_ACTIVE_GATE_I & gate_q;
	wire retr_edg = RAMP_RUN_O & UPPER_LIMIT_I;  // ramp to retrace
	wire ramp_beg = ~RAMP_RUN_O & LOWER_LIMIT_I & ~UPPER_LIMIT_I;
	wire major    = (col_minor == 3'h0);
	wire last_col = (step_cnt == COL_STEPS[5:0]);

	// dot limit for a column from its kind and the mode
	function [5:0] gss_dot_limit;
		input is_major;
		input is_video;
		begin
			if (is_major && is_video)
				gss_dot_limit = MAJOR_DOTS[5:0];
			else if (is_major || is_video)
				gss_dot_limit = MINOR_DOTS[5:0];
			else
				gss_dot_limit = 6'h00; // digitize minor column stays dark
		end
	endfunction

	// wrap-around increment shared by the three dividers
	function [5:0] gss_wrap_inc;
		input [5:0] val;
		input [5:0] modulus;
		begin
			if (val == modulus - 6'h01)
				gss_wrap_inc = 6'h00;
			else
				gss_wrap_inc = val + 6'h01;
		end
	endfunction

	wire [5:0] dot_lim  = gss_dot_limit(major, video);
	// divider next values, cut back to the counter widths on purpose
	wire [5:0] next_div_first = gss_wrap_inc({3'h0, div_first},
		DIV_FIRST[5:0]);
	wire [5:0] next_div_minor = gss_wrap_inc({3'h0, div_minor},
		DIV_MINOR[5:0]);
	// major video lines run at the fast rate, everything else slow
	wire       dot_tick = (major && video) ? tick625 : tick125;

	// clock dividers: 5 MHz edges to 625 kHz, 125 kHz and reference
	always @(posedge CLK_I)
	begin
		if (SYS_RST_I)
		begin
			ref_q       <= 1'b0;
			div_first   <= 3'h0;
			div_minor   <= 3'h0;
			div_ref     <= 6'h00;
			tick625     <= 1'b0;
			tick125     <= 1'b0;
			REF_PULSE_O <= 1'b0;
		end
		else if (CE_I)
		begin
			ref_q   <= REF_5M_I;
			tick625 <= 1'b0;
			tick125 <= 1'b0;
			REF_PULSE_O <= 1'b0;
			if (tick5)
			begin
				// eight input edges make one 625 kHz tick
				div_first <= next_div_first[2:0];
				tick625   <= (div_first == DIV_FIRST[2:0] - 3'h1);
			end
			if (tick625)
			begin
				div_minor <= next_div_minor[2:0];
				tick125   <= (div_minor == DIV_MINOR[2:0] - 3'h1);
				// modulus 45 gives one reference per vertical sweep
				div_ref     <= gss_wrap_inc(div_ref, DIV_REF[5:0]);
				REF_PULSE_O <= (div_ref == DIV_REF[5:0] - 6'h01);
			end
		end
	end

	// retrace flag: upper limit wins if both comparators fire together
	always @(posedge CLK_I)
	begin
		if (SYS_RST_I)
			RAMP_RUN_O <= 1'b0;
		else if (CE_I)
		begin
			if (UPPER_LIMIT_I)
				RAMP_RUN_O <= 1'b0;
			else if (LOWER_LIMIT_I)
				RAMP_RUN_O <= 1'b1;
		end
	end

	// phase comparator: pulse width tracks the gap between the events
	always @(posedge CLK_I)
	begin
		if (SYS_RST_I)
		begin
			SLOW_DOWN_O  <= 1'b0;
			SPEED_UP_N_O <= 1'b1;
		end
		else if (CE_I)
		begin
			if (retr_edg && REF_PULSE_O)
			begin
				// in step: both outputs stay cleared
				SLOW_DOWN_O  <= 1'b0;
				SPEED_UP_N_O <= 1'b1;
			end
			else if (retr_edg)
			begin
				if (!SPEED_UP_N_O)
					SPEED_UP_N_O <= 1'b1;
				else
					SLOW_DOWN_O  <= 1'b1;
			end
			else if (REF_PULSE_O)
			begin
				if (SLOW_DOWN_O)
					SLOW_DOWN_O  <= 1'b0;
				else
					SPEED_UP_N_O <= 1'b0;
			end
		end
	end

	// sequencer: sweep timing, lockout, selectors, columns and dots
	always @(posedge CLK_I)
	begin
		if (SYS_RST_I)
		begin
			state                <= ST_IDLE;
			gate_q               <= 1'b0;
			sweep_tmr            <= 16'h0000;
			slow_sweep           <= 1'b0;
			SWEEP_INHIBIT_O      <= 1'b0;
			CHAN_GRAT_O          <= 1'b0;
			STAIR_ADVANCE_O      <= 1'b0;
			COLUMN_STAIR_CLEAR_O <= 1'b1;
			step_cnt             <= 6'h00;
			col_minor            <= 3'h0;
			dot_cnt              <= 6'h00;
			DOT_O                <= 1'b0;
		end
		else if (CE_I)
		begin
			gate_q <= SWEEP_ACTIVE_GATE_I;
			DOT_O  <= 1'b0;
			case (state)
				ST_IDLE:
				begin
					sweep_tmr <= 16'h0000;
					if (overlay)
					begin
						// overlay only: no sweep to wait for
						SWEEP_INHIBIT_O <= 1'b1;
						CHAN_GRAT_O     <= 1'b1;
						state           <= ST_SYNC;
					end
					else if (g_rise)
						state <= ST_SWEEP;
				end
				ST_SWEEP:
				begin
					// saturate so a very long sweep cannot wrap to fast
					if (sweep_tmr < SLOW_CYC[15:0])
						sweep_tmr <= sweep_tmr + 16'h0001;
					if (overlay)
					begin
						SWEEP_INHIBIT_O <= 1'b1;
						CHAN_GRAT_O     <= 1'b1;
						state           <= ST_SYNC;
					end
					else if (g_fall)
					begin
						// slow sweeps are locked out, fast ones keep running
						slow_sweep      <= (sweep_tmr >= SLOW_CYC[15:0]);
						SWEEP_INHIBIT_O <= (sweep_tmr >= SLOW_CYC[15:0]);
						CHAN_GRAT_O     <= 1'b1;
						state           <= ST_SYNC;
					end
				end
				ST_SYNC:
				begin
					// first column waits for a fresh ramp from the bottom
					if (ramp_beg)
					begin
						COLUMN_STAIR_CLEAR_O <= 1'b0;
						step_cnt             <= 6'h00;
						col_minor            <= 3'h0;
						dot_cnt              <= 6'h00;
						state                <= ST_WRITE;
					end
				end
				ST_WRITE:
				begin
					if (retr_edg)
					begin
						dot_cnt <= 6'h00;
						if (last_col)
						begin
							// frame done: hand the deflection back
							COLUMN_STAIR_CLEAR_O <= 1'b1;
							CHAN_GRAT_O          <= 1'b0;
							SWEEP_INHIBIT_O      <= 1'b0;
							STAIR_ADVANCE_O      <= 1'b0;
							state                <= ST_IDLE;
						end
						else
						begin
							// one minor step right during this retrace
							STAIR_ADVANCE_O <= 1'b1;
							step_cnt        <= step_cnt + 6'h01;
							if (col_minor == `GSS_MINOR_PER_MAJOR - 1)
								col_minor <= 3'h0;
							else
								col_minor <= col_minor + 3'h1;
						end
					end
					else if (LOWER_LIMIT_I)
						STAIR_ADVANCE_O <= 1'b0;
					else if (RAMP_RUN_O && dot_tick && dot_cnt < dot_lim)
					begin
						// dots only while the beam climbs the column
						DOT_O   <= 1'b1;
						dot_cnt <= dot_cnt + 6'h01;
					end
				end
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	// register port: control write, status and column readback
	always @(posedge CLK_I)
	begin
		if (SYS_RST_I)
		begin
			ctrl    <= `GSS_CTRL_RESET;
			RDATA_O <= 8'h00;
		end
		else if (CE_I)
		begin
			RDATA_O <= 8'h00;
			if (WR_I && ADDR_I == `GSS_OFS_CTRL)
				ctrl <= WDATA_I & 8'h03; // only two bits implemented
			if (RD_I)
			begin
				case (ADDR_I)
					`GSS_OFS_CTRL:
						RDATA_O <= ctrl;
					`GSS_OFS_STATUS:
					begin
						RDATA_O <= {2'h0, RAMP_RUN_O, slow_sweep,
							COLUMN_STAIR_CLEAR_O, CHAN_GRAT_O,
							SWEEP_INHIBIT_O, ~state[0]};
					end
					`GSS_OFS_COLUMN:
						RDATA_O <= {2'h0, step_cnt};
					default:
						RDATA_O <= 8'h00; // unmapped reads as zero
				endcase
			end
		end
	end

endmodule // gss_sequencer

/* File: verification/gss_monitor.sv */
// port checker for the graticule scan sequencer
module gss_monitor (
	input wire CLK_I,           // clock
	input wire SYS_RST_I,       // reset
	input wire CE_I,            // run enable
	input wire UPPER_LIMIT_I,   // ramp top
	input wire LOWER_LIMIT_I,   // ramp bottom
	input wire STAIR_ADVANCE_O, // stair rising
	input wire REF_PULSE_O,     // reference
	input wire RAMP_RUN_O,      // ramp flag
	input wire SLOW_DOWN_O,     // slow-down
	input wire SPEED_UP_N_O     // speed-up, low
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (SYS_RST_I);
	// retrace edge: top reached while the ramp runs
	wire retrace = UPPER_LIMIT_I && RAMP_RUN_O;
	slow_rise_a: assert property (
		$rose(SLOW_DOWN_O) |-> $past(retrace))
		else $error("slow-down rose without retrace");
	slow_drop_a: assert property (
		$fell(SLOW_DOWN_O) |-> $past(REF_PULSE_O) || $past(SYS_RST_I))
		else $error("slow-down fell without reference");
	speed_fall_a: assert property (
		$fell(SPEED_UP_N_O) |-> $past(REF_PULSE_O))
		else $error("speed-up set without reference");
	speed_rise_a: assert property (
		$rose(SPEED_UP_N_O) |-> $past(retrace) || $past(SYS_RST_I))
		else $error("speed-up freed without retrace");
	upper_wins_a: assert property (
		CE_I && UPPER_LIMIT_I |=> !RAMP_RUN_O)
		else $error("upper limit kept the ramp");
	lower_sets_a: assert property (
		CE_I && LOWER_LIMIT_I && !UPPER_LIMIT_I |=> RAMP_RUN_O)
		else $error("lower limit missed");
	stair_hold_a: assert property (
		STAIR_ADVANCE_O |-> !RAMP_RUN_O)
		else $error("staircase moved during ramp");
	ref_single_a: assert property (
		REF_PULSE_O |=> !REF_PULSE_O [*8])
		else $error("reference pulse too long");
	cover property ($rose(SLOW_DOWN_O));
	cover property ($fell(SPEED_UP_N_O));
	cover property ($rose(STAIR_ADVANCE_O));
endmodule // gss_monitor

bind gss_sequencer gss_monitor gss_monitor_i (.CLK_I(CLK_I),
	.SYS_RST_I(SYS_RST_I), .CE_I(CE_I), .UPPER_LIMIT_I(UPPER_LIMIT_I),
	.LOWER_LIMIT_I(LOWER_LIMIT_I), .STAIR_ADVANCE_O(STAIR_ADVANCE_O),
	.REF_PULSE_O(REF_PULSE_O), .RAMP_RUN_O(RAMP_RUN_O),
	.SLOW_DOWN_O(SLOW_DOWN_O), .SPEED_UP_N_O(SPEED_UP_N_O));

/* File: verification/gss_timebase_model.sv */
// time base and graticule ramp model facing the sequencer
module gss_timebase_model #(
	parameter int RAMP_LEN = 460 // ramp rise, cycles
) (
	input  wire        clk_i,  // clock
	input  wire        rst_i,  // reset
	input  wire        ce_i,   // clock enable, low freezes the ramp
	input  wire        fire_i, // start a sweep
	input  wire  [7:0] len_i,  // sweep cycles
	input  wire        lock_i, // sweep lockout
	input  wire        run_i,  // ramp flag
	output logic       gate_o, // sweep gate
	output logic       up_o,   // top pulse
	output logic       low_o   // bottom pulse
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] left; // sweep cycles left
	int         age;  // cycles since flag moved
	logic       was;  // flag last cycle
	// a locked-out time base refuses to start
	always @(posedge clk_i)
		if (rst_i)
			gate_o <= 1'h0;
		else if (fire_i && !lock_i && !gate_o)
		begin
			gate_o <= 1'h1;
			left <= len_i;
		end
		else
		begin
			gate_o <= gate_o && left > 8'h01;
			left <= left - 8'h01;
		end
	// long rise, short retrace, so dots always fit
	// frozen with the sequencer, else a missed limit stalls the ramp
	always @(posedge clk_i)
		if (rst_i || ce_i)
		begin
			was <= run_i;
			age <= (rst_i || run_i != was) ? 0 : age + 1;
			up_o <= !rst_i && run_i && age == RAMP_LEN;
			low_o <= !rst_i && !run_i && age == 6;
		end
endmodule // gss_timebase_model

/* File: verification/tb.sv */
// self-checking bench for the graticule scan sequencer
`include "gss_map.vh"

module tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int DF = 2; // shortened first divider
	localparam int DR = 4; // shortened reference divider
	localparam int CS = 6; // shortened step count
	logic       clk, rst, ce, wr, rd, fire;
	logic [1:0] ph = 2'h0; // 5 MHz stand-in
	logic [3:0] addr;
	logic [7:0] wdata, len, d;
	wire  [7:0] rdata;
	wire        gate, up, low, inh, chan, adv, clr, dot, refp, run, slw, spn;
	int         bad_count = 0;
	int         comparisons = 0;
	int         t;
	// lockout expected, video select, gate cycles
	logic [9:0] rows [4] = '{10'h328, 10'h108, 10'h228, 10'h008};
	initial
	begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk)
		ph <= ph + 2'h1;
	gss_sequencer #(.SLOW_CYC(20), .DIV_FIRST(DF), .DIV_REF(DR),
		.COL_STEPS(CS)) gss_sequencer_i (.CLK_I(clk), .SYS_RST_I(rst),
		.CE_I(ce), .REF_5M_I(ph[1]), .SWEEP_ACTIVE_GATE_I(gate),
		.UPPER_LIMIT_I(up), .LOWER_LIMIT_I(low), .ADDR_I(addr),
		.WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
		.SWEEP_INHIBIT_O(inh), .CHAN_GRAT_O(chan), .STAIR_ADVANCE_O(adv),
		.COLUMN_STAIR_CLEAR_O(clr), .DOT_O(dot), .REF_PULSE_O(refp),
		.RAMP_RUN_O(run), .SLOW_DOWN_O(slw), .SPEED_UP_N_O(spn));
	gss_timebase_model gss_timebase_model_i (.clk_i(clk), .rst_i(rst),
		.ce_i(ce),
		.fire_i(fire), .len_i(len), .lock_i(inh), .run_i(run),
		.gate_o(gate), .up_o(up), .low_o(low));
	task chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// strobes change by NBA on a rising edge and last one cycle
	task wr_reg(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
	endtask
	task rd_reg(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		#1 d = rdata;
	endtask
	// one clock, then sample where outputs have settled
	task step;
		@(posedge clk);
		#1;
	endtask
	task wait_chan(input logic v, input int lim);
		for (t = 0; t < lim && chan !== v; t++)
			@(posedge clk);
		#1;
	endtask
	// one sweep, then count dots per column until the frame ends
	task frame(input logic [9:0] r);
		int c;
		logic [7:0] dots [16];
		logic pa;
		for (c = 0; c < 16; c++)
			dots[c] = 8'h00;
		wr_reg(`GSS_OFS_CTRL, {7'h00, r[8]});
		fire <= 1'h1;
		len <= r[7:0];
		@(posedge clk);
		fire <= 1'h0;
		wait_chan(1'h1, 400);
		chk({6'h00, chan, inh}, {6'h00, 1'h1, r[9]});
		c = 0;
		pa = 1'h0;
		while (chan === 1'h1 && t < 9000)
		begin
			@(posedge clk);
			#1;
			t++;
			if (dot === 1'h1)
				dots[c]++;
			if (adv === 1'h1 && pa === 1'h0)
				c++;
			pa = adv;
		end
		chk(8'(c), 8'(CS));
		for (c = 0; c <= CS; c++)
			if (c % 5 == 0)
				chk(dots[c], r[8] ? 8'h29 : 8'h09);
			else
				chk(dots[c], r[8] ? 8'h09 : 8'h00);
		chk({5'h00, chan, inh, clr}, 8'h01);
	endtask
	task finish_test;
		$display("comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		rst = 1'h1;
		ce = 1'h1;
		wr = 1'h0;
		rd = 1'h0;
		fire = 1'h0;
		addr = 4'h0;
		wdata = 8'h00;
		len = 8'h00;
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		#1 chk({clr, chan, inh, dot, slw, spn, run, 1'h0}, 8'h84);
		rd_reg(`GSS_OFS_CTRL);
		chk(d, 8'h01);
		wr_reg(`GSS_OFS_CTRL, 8'hFC);
		rd_reg(`GSS_OFS_CTRL);
		chk(d, 8'h00);
		wr_reg(`GSS_OFS_STATUS, 8'hFF);
		rd_reg(4'hF);
		chk(d, 8'h00);
		// reference spacing in system cycles, sampled 1 ns past edges
		for (t = 0; t < 200 && refp !== 1'h1; t++)
			step;
		step;
		for (t = 1; t < 200 && refp !== 1'h1; t++)
			step;
		chk(8'(t), 8'(DF * DR * 4));
		// ce low for 16 edges (whole 5 MHz periods) delays the next one
		@(posedge clk);
		ce <= 1'h0;
		repeat (16) @(posedge clk);
		ce <= 1'h1;
		#1;
		for (t = 17; t < 200 && refp !== 1'h1; t++)
			step;
		chk(8'(t), 8'(DF * DR * 4 + 16));
		foreach (rows[i])
			frame(rows[i]);
		rd_reg(`GSS_OFS_STATUS);
		chk({4'h0, d[3:0]}, 8'h08);
		wr_reg(`GSS_OFS_CTRL, 8'h03);
		wait_chan(1'h1, 8);
		chk({6'h00, inh, chan}, 8'h03);
		wr_reg(`GSS_OFS_CTRL, 8'h01);
		wait_chan(1'h0, 9000);
		chk({5'h00, chan, inh, clr}, 8'h01);
		// reset in mid-frame brings every output back to idle
		wr_reg(`GSS_OFS_CTRL, 8'h03);
		wait_chan(1'h1, 8);
		chk({6'h00, inh, chan}, 8'h03);
		@(posedge clk);
		rst <= 1'h1;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		#1 chk({clr, chan, inh, dot, slw, spn, run, adv}, 8'h84);
		rd_reg(`GSS_OFS_CTRL);
		chk(d, 8'h01);
		finish_test;
	end
	initial
	begin
		repeat (40000) @(posedge clk);
		bad_count++;
		finish_test;
	end
endmodule // tb
